// ### logic/buffered_link_init.sv
`timescale 1ns/100ps
module buffered_link_init import link_init_pkg::*; #(
  parameter int          FRAME_CYCLES = 12,
  parameter logic [19:0] CALIB_FRAMES = 20'd480000,
  parameter logic [3:0]  GOOD_FRAMES  = 4'd4
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output pattern_t         sb_pattern,
  output logic             sb_elec_idle,
  output logic [2:0]       sb_target_id,
  output logic             sb_failover,
  output logic             nb_failover,
  output logic [3:0]       failover_lane,
  output logic [4:0]       sb_crc_bits,
  output logic [4:0]       nb_crc_bits,
  input  wire logic [13:0] nb_lane_ok,
  input  wire logic [3:0]  nb_pattern,
  input  wire logic [2:0]  nb_id,
  output logic             tx_fifo_recenter_bit,
  output logic             selftest_rx_en,
  output logic             selftest_run,
  output logic [7:0]       sb_train_pattern_count,
  output logic [15:0]      train_min_time,
  input  wire logic        selftest_done,
  input  wire logic        selftest_err,
  input  wire logic [9:0]  selftest_sb_lane_ok,
  output logic             cmd_ready,
  output logic             refresh_enable
);
  typedef enum logic [3:0] {
    ST_DISABLE, ST_CALIB, ST_IDLE2, ST_TRAIN, ST_TEST_HDR, ST_TEST_BIST,
    ST_TEST_TRL, ST_TEST_CHK, ST_POLL, ST_CONFIG, ST_NOP, ST_ACTIVE
  } state_t;

  // Population count, shared by the lane checks on both directions.
  function automatic logic [3:0] ones(input logic [13:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 14; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction

  function automatic link_code_t code_of(input state_t s);
    unique case (s)
      ST_DISABLE, ST_IDLE2: return CODE_DISABLE;
      ST_CALIB: return CODE_CALIB;
      ST_TRAIN: return CODE_TRAIN;
      ST_TEST_HDR, ST_TEST_BIST, ST_TEST_TRL, ST_TEST_CHK: return CODE_TEST;
      ST_POLL: return CODE_POLL;
      ST_CONFIG: return CODE_CONFIG;
      ST_NOP, ST_ACTIVE: return CODE_ACTIVE;
    endcase
  endfunction

  function automatic pattern_t pat_of(input state_t s);
    unique case (s)
      ST_DISABLE, ST_IDLE2: return PAT_IDLE;
      ST_CALIB: return PAT_CALIB;
      ST_TRAIN: return PAT_TS0;
      ST_TEST_HDR: return PAT_TS1_HDR;
      ST_TEST_BIST: return PAT_BIST;
      ST_TEST_TRL: return PAT_TS1_TRL;
      ST_TEST_CHK: return PAT_TS1;
      ST_POLL: return PAT_TS2;
      ST_CONFIG: return PAT_TS3;
      ST_NOP: return PAT_NOP;
      ST_ACTIVE: return PAT_CMD;
    endcase
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    return a == ADDR_CTRL || a == ADDR_STATE || a == ADDR_STATUS || a == ADDR_LANE ||
           a == ADDR_SELFTEST || a == ADDR_RTT || a == ADDR_MINTIME;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Northbound pins come from the link receivers, so each passes two flops first.
  logic [13:0] ok_m, ok_s;
  logic [3:0]  pat_m, pat_s;
  logic [2:0]  id_m, id_s;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ok_m  <= '0;
      ok_s  <= '0;
      pat_m <= '0;
      pat_s <= '0;
      id_m  <= '0;
      id_s  <= '0;
    end else begin
      ok_m  <= nb_lane_ok;
      ok_s  <= ok_m;
      pat_m <= nb_pattern;
      pat_s <= pat_m;
      id_m  <= nb_id;
      id_s  <= id_m;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB register file; read data is caught in the setup cycle, so no wait states.
  logic [10:0] ctrl, next_ctrl;
  logic        rx_start, next_rx_start;
  logic [7:0]  tcount, next_tcount;
  logic        st_err, next_st_err, st_done, next_st_done;
  logic [3:0]  lane_sel, next_lane_sel;
  logic [15:0] mintime, next_mintime;
  logic [31:0] next_prdata;
  logic        wr, start_req, wr_state, bist_req;
  state_t      state;
  logic        auto_run, rtt_valid;
  logic [15:0] rtt_cnt;
  logic [7:0]  lane_cnt [14];

  always_comb begin
    wr            = psel && penable && pwrite;
    next_ctrl     = ctrl;
    next_rx_start = rx_start;
    next_tcount   = tcount;
    next_lane_sel = lane_sel;
    next_mintime  = mintime;
    next_prdata   = prdata;
    // Hardware set wins over a software clear in the same cycle.
    next_st_err   = st_err | (selftest_run & selftest_err); // [R17]
    next_st_done  = st_done | (selftest_run & selftest_done);
    bist_req      = wr && paddr == ADDR_SELFTEST && pwdata[ST_TX_START] && rx_start; // [R17]
    start_req     = (wr && paddr == ADDR_CTRL && pwdata[CTRL_START]) || bist_req; // [R4]
    wr_state      = wr && paddr == ADDR_STATE && pwdata[2:0] <= CODE_ACTIVE;
    if (wr) begin
      unique case (paddr)
        ADDR_CTRL: next_ctrl = {pwdata[10:1], 1'b0};
        ADDR_LANE: next_lane_sel = pwdata[3:0];
        ADDR_MINTIME: next_mintime = pwdata[15:0];
        ADDR_SELFTEST: begin
          next_rx_start = pwdata[ST_RX_START];
          next_tcount   = pwdata[ST_CNT_LSB +: 8];
          if (pwdata[ST_ERR] && !(selftest_run & selftest_err)) begin
            next_st_err = 1'b0;
          end
          if (pwdata[ST_DONE] && !(selftest_run & selftest_done)) begin
            next_st_done = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        ADDR_CTRL: next_prdata = {21'h0, ctrl};
        ADDR_STATE: next_prdata = {29'h0, code_of(state)}; // [R23]
        ADDR_STATUS: next_prdata = {12'h0, ones(ok_s), 8'h0, 2'h0, rtt_valid,
                                    state == ST_ACTIVE, auto_run, code_of(state)};
        // Selects past the last lane have no counter and read a zero count.
        ADDR_LANE: next_prdata = {16'h0, (lane_sel < 4'(NB_LANES) ? lane_cnt[lane_sel] : 8'h00),
                                  4'h0, lane_sel}; // [R8]
        ADDR_SELFTEST: next_prdata = {14'h0, st_done, st_err, tcount, 7'h0, rx_start};
        ADDR_RTT: next_prdata = {16'h0, rtt_cnt}; // [R11]
        ADDR_MINTIME: next_prdata = {16'h0, mintime};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ctrl     <= CTRL_RESET;
      rx_start <= 1'b0;
      tcount   <= CNT_RESET;
      st_err   <= 1'b0;
      st_done  <= 1'b0;
      lane_sel <= 4'h0;
      mintime  <= MINTIME_RESET;
      prdata   <= 32'h0000_0000;
    end else begin
      ctrl     <= next_ctrl;
      rx_start <= next_rx_start;
      tcount   <= next_tcount;
      st_err   <= next_st_err;
      st_done  <= next_st_done;
      lane_sel <= next_lane_sel;
      mintime  <= next_mintime;
      prdata   <= next_prdata;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok(paddr);

  ////////////////////////////////////////////////////////////////////////////////
  // Lane setup and CRC widths follow the failover choice in the control word.
  assign tx_fifo_recenter_bit   = ctrl[CTRL_RECENTER]; // [R5]
  assign sb_failover            = ctrl[CTRL_SB_FO]; // [R1]
  assign nb_failover            = ctrl[CTRL_NB_FO]; // [R1]
  assign failover_lane          = ctrl[CTRL_LANE_LSB +: 4];
  assign sb_target_id           = ctrl[CTRL_ID_LSB +: 3]; // [R15]
  assign sb_crc_bits            = sb_failover ? SB_CRC_FO : SB_CRC_FULL; // [R2]
  assign nb_crc_bits            = nb_failover ? NB_CRC_FO : NB_CRC_FULL; // [R3]
  assign selftest_rx_en         = rx_start;
  assign sb_train_pattern_count = tcount;
  assign train_min_time         = mintime;

  ////////////////////////////////////////////////////////////////////////////////
  // Bring-up sequencer; stage timers count whole frames, not clock cycles.
  localparam int FW = $clog2(FRAME_CYCLES);
  localparam logic [FW-1:0] FRAME_LAST = FW'(FRAME_CYCLES - 1);
  logic [FW-1:0] frame, next_frame;
  logic [19:0]   timer, next_timer;
  logic [3:0]    good_run, next_good;
  state_t        cand, next_state;
  logic          next_auto, bist_en, next_bist, next_rtt_valid, next_idle;
  logic          tick, nb_good, rx_ok;
  logic [15:0]   next_rtt;
  pattern_t      next_pattern;
  logic [7:0]    next_lane_cnt [14];

  always_comb begin
    tick           = frame == FRAME_LAST;
    nb_good        = ones(ok_s) >= MIN_NB_LANES && id_s == sb_target_id; // [R8] [R10]
    rx_ok          = nb_good && pat_s == sb_pattern;
    next_frame     = tick ? '0 : frame + 1'b1;
    next_timer     = tick ? timer + 20'h1 : timer;
    next_good      = good_run;
    next_auto      = auto_run;
    next_bist      = bist_en;
    next_rtt       = rtt_cnt;
    next_rtt_valid = rtt_valid;
    next_lane_cnt  = lane_cnt;
    if (tick) begin
      next_good = !rx_ok ? 4'h0 : (good_run == 4'hF ? good_run : good_run + 4'h1);
    end
    cand = state;
    unique case (state)
      ST_DISABLE: if (tick && timer + 20'h1 >= T_DISABLE_FRAMES) cand = ST_CALIB; // [R6]
      ST_CALIB: if (tick && timer + 20'h1 >= CALIB_FRAMES) cand = ST_IDLE2; // [R7]
      ST_IDLE2: if (tick && timer + 20'h1 >= T_DISABLE_FRAMES) cand = ST_TRAIN; // [R7]
      ST_TRAIN: if (tick && rx_ok && good_run + 4'h1 >= GOOD_FRAMES) cand = ST_TEST_HDR; // [R8]
      ST_TEST_HDR: if (tick) cand = bist_en ? ST_TEST_BIST : ST_TEST_TRL; // [R9]
      ST_TEST_BIST: if (selftest_done) cand = ST_TEST_TRL; // [R9]
      ST_TEST_TRL: if (tick) cand = ST_TEST_CHK; // [R9]
      ST_TEST_CHK: begin
        if (tick && rx_ok && ones({4'h0, selftest_sb_lane_ok}) >= MIN_SB_LANES &&
            good_run + 4'h1 >= GOOD_FRAMES) cand = ST_POLL; // [R10]
      end
      ST_POLL: if (tick && rx_ok && good_run + 4'h1 >= GOOD_FRAMES) cand = ST_CONFIG; // [R11]
      ST_CONFIG: if (tick && rx_ok && good_run + 4'h1 >= GOOD_FRAMES) cand = ST_NOP; // [R13]
      ST_NOP: if (tick && timer + 20'h1 >= NOP_FRAMES) cand = ST_ACTIVE; // [R14]
      ST_ACTIVE: cand = ST_ACTIVE;
    endcase
    // Under manual control only the steps inside one stage code may advance.
    if (!auto_run && code_of(cand) != code_of(state)) cand = state;
    if (start_req) begin
      cand      = ST_DISABLE;
      next_auto = 1'b1; // [R4]
      next_bist = bist_req; // [R17]
    end else if (wr_state) begin
      next_auto = 1'b0;
      unique case (pwdata[2:0])
        CODE_DISABLE: cand = ST_DISABLE; // [R23]
        CODE_CALIB: cand = ST_CALIB;
        CODE_TRAIN: cand = ST_TRAIN;
        CODE_TEST: cand = ST_TEST_HDR;
        CODE_POLL: cand = ST_POLL;
        CODE_CONFIG: cand = ST_CONFIG;
        default: cand = ST_NOP;
      endcase
    end
    if (cand != state || start_req || wr_state) begin
      next_timer = '0;
      next_good  = '0;
      next_frame = '0;
    end
    // Round trip: cycles from polling entry to the first correct echo.
    if (state == ST_POLL && !rtt_valid) begin
      next_rtt       = rtt_cnt + 16'h1;
      next_rtt_valid = rx_ok; // [R11]
    end
    if (cand == ST_POLL && state != ST_POLL) begin
      next_rtt       = '0;
      next_rtt_valid = 1'b0;
    end
    for (int i = 0; i < NB_LANES; i++) begin
      if (cand == ST_TRAIN && state != ST_TRAIN) begin
        next_lane_cnt[i] = 8'h00;
      end else if (state == ST_TRAIN && tick && ok_s[i] && pat_s == PAT_TS0 &&
                   id_s == sb_target_id && lane_cnt[i] != 8'hFF) begin
        next_lane_cnt[i] = lane_cnt[i] + 8'h01; // [R8]
      end
    end
    next_state   = cand;
    next_pattern = pat_of(cand); // [R23]
    next_idle    = pat_of(cand) == PAT_IDLE; // [R6] [R22]
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state        <= ST_DISABLE;
      frame        <= '0;
      timer        <= '0;
      good_run     <= '0;
      auto_run     <= 1'b0;
      bist_en      <= 1'b0;
      rtt_cnt      <= '0;
      rtt_valid    <= 1'b0;
      sb_pattern   <= PAT_IDLE;
      sb_elec_idle <= 1'b1;
      for (int i = 0; i < NB_LANES; i++) lane_cnt[i] <= 8'h00;
    end else begin
      state        <= next_state;
      frame        <= next_frame;
      timer        <= next_timer;
      good_run     <= next_good;
      auto_run     <= next_auto;
      bist_en      <= next_bist;
      rtt_cnt      <= next_rtt;
      rtt_valid    <= next_rtt_valid;
      sb_pattern   <= next_pattern;
      sb_elec_idle <= next_idle;
      lane_cnt     <= next_lane_cnt;
    end
  end

  assign selftest_run   = state == ST_TEST_BIST; // [R9] [R15]
  // Commands, DRAM command words included, wait until the NOP frames are out.
  assign cmd_ready      = state == ST_ACTIVE; // [R14] [R21]
  assign refresh_enable = state == ST_ACTIVE; // [R22]

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on the sequencer and the CRC widths.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  property p_idle;
    state == ST_DISABLE || state == ST_IDLE2 |-> sb_elec_idle && sb_pattern == PAT_IDLE;
  endproperty
  a_idle: assert property (p_idle) else $error("idle not driven"); // [R6]
  property p_dis_time;
    state == ST_DISABLE && next_state == ST_CALIB && !wr_state |-> timer == T_DISABLE_FRAMES - 1;
  endproperty
  a_dis_time: assert property (p_dis_time) else $error("disable too short"); // [R6]
  property p_cal_time;
    state == ST_CALIB ##1 state == ST_IDLE2 |-> $past(timer) == CALIB_FRAMES - 1 &&
                                               CALIB_FRAMES > 2 * T_CLKTRAIN_FRAMES;
  endproperty
  a_cal_time: assert property (p_cal_time) else $error("calibrate too short"); // [R7]
  property p_train;
    state == ST_TRAIN && next_state == ST_TEST_HDR && !wr_state |-> nb_good && pat_s == PAT_TS0;
  endproperty
  a_train: assert property (p_train) else $error("training left early"); // [R8]
  property p_bist;
    state == ST_TEST_BIST && selftest_done && !wr_state && !start_req |=>
      state == ST_TEST_TRL && sb_pattern == PAT_TS1_TRL;
  endproperty
  a_bist: assert property (p_bist) else $error("trailer missed"); // [R9]
  property p_test_exit;
    state == ST_TEST_CHK ##1 state == ST_POLL && !$past(wr_state) |->
      $past(ones({4'h0, selftest_sb_lane_ok})) >= MIN_SB_LANES;
  endproperty
  a_test_exit: assert property (p_test_exit) else $error("too few lanes"); // [R10]
  property p_rtt;
    state == ST_POLL ##1 state == ST_CONFIG && $past(auto_run) |-> rtt_valid;
  endproperty
  a_rtt: assert property (p_rtt) else $error("round trip not taken"); // [R11]
  property p_nops;
    $rose(cmd_ready) |-> $past(sb_pattern == PAT_NOP, 1) && $past(state) == ST_NOP;
  endproperty
  a_nops: assert property (p_nops) else $error("active without NOPs"); // [R14]
  property p_code;
    wr_state && !start_req |=> code_of(state) == $past(pwdata[2:0]);
  endproperty
  a_code: assert property (p_code) else $error("state write lost"); // [R23]
  property p_crc;
    sb_crc_bits == (sb_failover ? 5'd10 : 5'd22) && nb_crc_bits == (nb_failover ? 5'd12 : 5'd24);
  endproperty
  a_crc: assert property (p_crc) else $error("crc width wrong"); // [R2] [R3]
  c_active: cover property (auto_run && $rose(cmd_ready));
  c_bist: cover property (bist_en && selftest_run && selftest_done);
  c_manual: cover property (wr_state ##1 state == ST_TRAIN);
endmodule // buffered_link_init

// ### logic/link_init_pkg.sv
// Overview of operation
// [R1] Southbound runs 10 lanes or failover; northbound 14 lanes or failover.
// [R2] Southbound CRC is 22 bits full, 10 bits in failover.
// [R3] Northbound CRC is 24 bits full (12 per packet), 12 in failover.
// [R4] A software start runs the whole bring-up in hardware without stepping.
// [R5] Software pulses the FIFO re-center bit 0, 1, 0 before transmitting.
// [R6] Disable drives electrical idle for at least 51 frames before calibrate.
// [R7] Calibrate exceeds twice 42 and at least 480K frames; then idle 51.
// [R8] Training sends pattern 0 until last ID returns on 13 of 14 lanes.
// [R9] Testing sends header, runs the self-test engine, then the trailer.
// [R10] Leaving testing needs last ID, 9 southbound and 13 northbound lanes.
// [R11] Polling sends pattern 2 until echoed and measures round-trip delay.
// [R12] A buffer that fails merging sets its status bit for software.
// [R13] Config sends pattern 3 with lane setup until echoed correctly.
// [R14] Active starts with four NOP frames before commands are accepted.
// [R15] Self-test patterns go to a target buffer and loop back for checking.
// [R16] Software sets pattern count times 12 above minimum time plus 240.
// [R17] Receive engine first; transmit start runs all stages, logging errors.
// [R18] No management traffic for 2 ms after buffer reset release.
// [R19] Wait 200 microseconds after next link frequency write.
// [R20] Pending buffer settings become current before training begins.
// [R21] DRAM command: address, then command with bit 31; poll its clear.
// [R22] Disable puts DRAMs in self-refresh; host refreshes once active.
// [R23] Each stage has its own code; writing one changes the pattern at once.
package link_init_pkg;
  ////////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATE = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_LANE = 8'h0C;
  localparam logic [7:0] ADDR_SELFTEST = 8'h10;
  localparam logic [7:0] ADDR_RTT = 8'h14;
  localparam logic [7:0] ADDR_MINTIME = 8'h18;
  localparam int CTRL_START = 0;
  localparam int CTRL_SB_FO = 1;
  localparam int CTRL_NB_FO = 2;
  localparam int CTRL_RECENTER = 3;
  localparam int CTRL_LANE_LSB = 4;
  localparam int CTRL_ID_LSB = 8;
  localparam int ST_RX_START = 0;
  localparam int ST_TX_START = 1;
  localparam int ST_CNT_LSB = 8;
  localparam int ST_ERR = 16;
  localparam int ST_DONE = 17;
  localparam logic [10:0] CTRL_RESET = 11'h700;
  localparam logic [7:0] CNT_RESET = 8'h40;
  localparam logic [15:0] MINTIME_RESET = 16'h0000;
  ////////////////////////////////////////////////////////////////////////////////
  localparam int SB_LANES = 10;
  localparam int NB_LANES = 14;
  localparam logic [4:0] SB_CRC_FULL = 5'd22;
  localparam logic [4:0] SB_CRC_FO = 5'd10;
  localparam logic [4:0] NB_CRC_FULL = 5'd24;
  localparam logic [4:0] NB_CRC_FO = 5'd12;
  localparam logic [3:0] MIN_NB_LANES = 4'd13;
  localparam logic [3:0] MIN_SB_LANES = 4'd9;
  localparam logic [19:0] T_DISABLE_FRAMES = 20'd51;
  localparam logic [19:0] T_CLKTRAIN_FRAMES = 20'd42;
  localparam logic [19:0] NOP_FRAMES = 20'd4;
  ////////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    CODE_DISABLE = 3'h0, CODE_CALIB = 3'h1, CODE_TRAIN = 3'h2, CODE_TEST = 3'h3,
    CODE_POLL = 3'h4, CODE_CONFIG = 3'h5, CODE_ACTIVE = 3'h6
  } link_code_t;
  typedef enum logic [3:0] {
    PAT_IDLE = 4'h0, PAT_CALIB = 4'h1, PAT_TS0 = 4'h2, PAT_TS1_HDR = 4'h3,
    PAT_BIST = 4'h4, PAT_TS1_TRL = 4'h5, PAT_TS1 = 4'h6, PAT_TS2 = 4'h7,
    PAT_TS3 = 4'h8, PAT_NOP = 4'h9, PAT_CMD = 4'hA
  } pattern_t;
endpackage

// ### bench/amb_chain_model.sv
`timescale 1ns/100ps
module amb_chain_model import link_init_pkg::*; #(
  parameter logic [2:0] LAST_ID = 3'd7
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire pattern_t    sb_pattern,
  input  wire logic        sb_elec_idle,
  input  wire logic        selftest_run,
  input  wire logic [13:0] bad_lanes,
  output logic [13:0]      nb_lane_ok,
  output logic [3:0]       nb_pattern,
  output logic [2:0]       nb_id,
  output logic             selftest_done,
  output logic             selftest_err,
  output logic [9:0]       selftest_sb_lane_ok
);
  logic [2:0] loop_cnt;
  ////////////////////////////////////////////////////////////////////////////////
  // An idle link returns noise that flips every cycle, so a stale echo never passes.
  // Every buffer merges cleanly here, so none raises its merge-failure status.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      nb_pattern <= 4'h5;
      nb_id      <= 3'h2;
      nb_lane_ok <= 14'h0000;
    end else if (sb_elec_idle) begin
      nb_pattern <= ~nb_pattern;
      nb_id      <= ~nb_id;
      nb_lane_ok <= 14'h0000;
    end else begin
      nb_pattern <= sb_pattern;
      nb_id      <= LAST_ID;
      nb_lane_ok <= ~bad_lanes;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // The loopback run ends after a short fixed time with all southbound lanes good.
  always_ff @(posedge clk_sys) begin
    if (!rst_b || !selftest_run) begin
      loop_cnt <= 3'h0;
    end else if (loop_cnt != 3'h7) begin
      loop_cnt <= loop_cnt + 3'h1;
    end
  end
  assign selftest_done       = (loop_cnt == 3'h6);
  assign selftest_err        = 1'b0;
  assign selftest_sb_lane_ok = 10'h3FF;
endmodule  // amb_chain_model

// ### bench/buffered_dimm_link_init_tb.sv
`timescale 1ns/100ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
  $display("Error at %0t: got %0h expected %0h", $time, (a), (e)); end end
module buffered_dimm_link_init_tb import link_init_pkg::*;;
  localparam int FC = 3;
  localparam logic [19:0] CF = 20'd100;
  logic        clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, perr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  pattern_t    sb_pattern;
  logic        sb_elec_idle, sb_failover, nb_failover, tx_fifo_recenter_bit;
  logic [2:0]  sb_target_id, nb_id;
  logic [3:0]  failover_lane, nb_pattern;
  logic [4:0]  sb_crc_bits, nb_crc_bits;
  logic [13:0] nb_lane_ok, bad_lanes;
  logic        selftest_rx_en, selftest_run, selftest_done, selftest_err;
  logic        cmd_ready, refresh_enable;
  logic [7:0]  sb_train_pattern_count;
  logic [15:0] train_min_time;
  logic [9:0]  selftest_sb_lane_ok;
  int          n_fail, cmp_count, n;
  pattern_t    seq[9] = '{PAT_TS0, PAT_TS1_HDR, PAT_BIST, PAT_TS1_TRL, PAT_TS1,
                          PAT_TS2, PAT_TS3, PAT_NOP, PAT_CMD};
  buffered_link_init #(.FRAME_CYCLES(FC), .CALIB_FRAMES(CF)) dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sb_pattern(sb_pattern), .sb_elec_idle(sb_elec_idle), .sb_target_id(sb_target_id),
    .sb_failover(sb_failover), .nb_failover(nb_failover), .failover_lane(failover_lane),
    .sb_crc_bits(sb_crc_bits), .nb_crc_bits(nb_crc_bits), .nb_lane_ok(nb_lane_ok),
    .nb_pattern(nb_pattern), .nb_id(nb_id), .tx_fifo_recenter_bit(tx_fifo_recenter_bit),
    .selftest_rx_en(selftest_rx_en), .selftest_run(selftest_run),
    .sb_train_pattern_count(sb_train_pattern_count), .train_min_time(train_min_time),
    .selftest_done(selftest_done), .selftest_err(selftest_err),
    .selftest_sb_lane_ok(selftest_sb_lane_ok), .cmd_ready(cmd_ready),
    .refresh_enable(refresh_enable));
  amb_chain_model amb (
    .clk_sys(clk_sys), .rst_b(rst_b), .sb_pattern(sb_pattern), .sb_elec_idle(sb_elec_idle),
    .selftest_run(selftest_run), .bad_lanes(bad_lanes), .nb_lane_ok(nb_lane_ok),
    .nb_pattern(nb_pattern), .nb_id(nb_id), .selftest_done(selftest_done),
    .selftest_err(selftest_err), .selftest_sb_lane_ok(selftest_sb_lane_ok));
  ////////////////////////////////////////////////////////////////////////////////
  // One APB transfer; read data and error are taken only at the edge with pready high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  // Bounded wait for a southbound pattern; n returns the cycles spent waiting.
  task automatic wait_pat(input pattern_t p, input int lim);
    n = 0;
    while (sb_pattern !== p && n < lim) begin
      @(posedge clk_sys); #1; n++;
    end
    `CHK(sb_pattern, p)
  endtask
  task automatic walk(input int first, input int last);
    for (int i = first; i <= last; i++) wait_pat(seq[i], 1200 * FC);
  endtask
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    `CHK(sb_elec_idle, 1'b1)
    `CHK(sb_target_id, 3'h7)
    apb(0, ADDR_CTRL, 32'h0); `CHK(rd[10:0], CTRL_RESET)
    apb(0, ADDR_SELFTEST, 32'h0); `CHK(rd[15:8], CNT_RESET)
    apb(0, 8'h3C, 32'h0); `CHK({perr, rd}, 33'h100000000)
  endtask
  // Every lane setup selects its own CRC widths; the FIFO re-center bit goes 0, 1, 0.
  task automatic t_lanes();
    for (int i = 0; i < 4; i++) begin
      apb(1, ADDR_CTRL, 32'h700 | (i << 1) | (i << 4));
      `CHK(failover_lane, i[3:0])
      `CHK({sb_failover, nb_failover}, {i[0], i[1]})
      `CHK(sb_crc_bits, i[0] ? SB_CRC_FO : SB_CRC_FULL)
      `CHK(nb_crc_bits, i[1] ? NB_CRC_FO : NB_CRC_FULL)
    end
    apb(1, ADDR_CTRL, 32'h708); `CHK(tx_fifo_recenter_bit, 1'b1)
    apb(1, ADDR_CTRL, 32'h700); `CHK(tx_fifo_recenter_bit, 1'b0)
  endtask
  // Automatic bring-up; two dead lanes hold training until one of them recovers.
  task automatic t_bringup();
    @(posedge clk_sys); bad_lanes <= 14'h0003;
    apb(1, ADDR_CTRL, 32'h701);
    wait_pat(PAT_CALIB, 60 * FC); `CHK(n >= 51 * FC, 1'b1)
    wait_pat(PAT_IDLE, CF * FC + 9); `CHK(n >= CF * FC, 1'b1)
    wait_pat(PAT_TS0, 60 * FC); `CHK(n >= 51 * FC, 1'b1)
    repeat (30 * FC) @(posedge clk_sys);
    #1; `CHK(sb_pattern, PAT_TS0)
    apb(1, ADDR_LANE, 32'h0); apb(0, ADDR_LANE, 32'h0); `CHK(rd[15:8], 8'h00)
    apb(1, ADDR_LANE, 32'h5); apb(0, ADDR_LANE, 32'h0); `CHK(rd[15:8] > 8'h10, 1'b1)
    @(posedge clk_sys); bad_lanes <= 14'h0001;
    walk(4, 7); `CHK(cmd_ready, 1'b0)
    wait_pat(PAT_CMD, 9 * FC); `CHK(n >= 4 * FC && n <= 4 * FC + 1, 1'b1)
    `CHK({cmd_ready, refresh_enable}, 2'b11)
    apb(0, ADDR_STATUS, 32'h0); `CHK({rd[5], rd[2:0]}, {1'b1, CODE_ACTIVE})
    apb(0, ADDR_RTT, 32'h0); `CHK(rd[15:0] >= 16'h3 && rd[15:0] < 16'h10, 1'b1)
  endtask
  // The transmit start is refused until the receive engine runs, then tests in stage three.
  task automatic t_selftest();
    apb(1, ADDR_MINTIME, 32'h100); `CHK(train_min_time, 16'h0100)
    apb(1, ADDR_SELFTEST, 32'h4002);
    repeat (3 * FC) @(posedge clk_sys);
    #1; `CHK(sb_pattern, PAT_CMD)
    apb(1, ADDR_SELFTEST, 32'h4001); `CHK(selftest_rx_en, 1'b1)
    `CHK(sb_train_pattern_count, 8'h40)
    apb(1, ADDR_SELFTEST, 32'h4003);
    walk(0, 2); `CHK(selftest_run, 1'b1)
    walk(3, 8);
    apb(0, ADDR_SELFTEST, 32'h0); `CHK(rd[17:16], 2'b10)
    // Writing one to the done flag clears it once the engine is idle.
    apb(1, ADDR_SELFTEST, 32'h24001);
    apb(0, ADDR_SELFTEST, 32'h0); `CHK(rd[17:16], 2'b00)
  endtask
  // Each written stage code reads back and has changed the pattern by the edge after the one that takes the write.
  task automatic t_manual();
    logic [2:0] mc[7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
    pattern_t   mp[7] = '{PAT_IDLE, PAT_CALIB, PAT_TS0, PAT_TS1_HDR, PAT_TS2, PAT_TS3, PAT_NOP};
    for (int i = 0; i < 7; i++) begin
      apb(1, ADDR_STATE, {29'h0, mc[i]});
      @(posedge clk_sys); #1;
      `CHK({sb_pattern, sb_elec_idle}, {mp[i], mc[i] == 3'h0})
      apb(0, ADDR_STATE, 32'h0); `CHK(rd[2:0], mc[i])
    end
    apb(1, ADDR_STATE, 32'h7); apb(0, ADDR_STATE, 32'h0); `CHK(rd[2:0], 3'h6)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Clock, then reset held four cycles before the scenarios run in order.
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    n_fail = 0; cmp_count = 0; rst_b = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; bad_lanes = 14'h0000;
    repeat (4) @(posedge clk_sys);
    // No management traffic is issued, so the buffers' quiet times and setting copies hold.
    rst_b <= 1'b1;
    #1;
    t_reset(); t_lanes(); t_bringup(); t_selftest(); t_manual();
    close_out();
  end
  // The whole run needs about 1600 cycles; over twelve times that means a hang.
  initial begin
    #400000;
    n_fail++;
    close_out();
  end
endmodule  // buffered_dimm_link_init_tb
